// >>> include/stp_cfg.svh
// Offsets, field positions and reset values of the port tuning registers
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

`define STP_OFF_ROLE_CTRL    8'h68
`define STP_OFF_TEST_AUX     8'h6C
`define STP_OFF_TIMER_OVR    8'h70
`define STP_OFF_FWD_MODE     8'h74

`define STP_RST_ROLE_CTRL    32'h04001060
`define STP_RST_TEST_AUX     32'h04000800
`define STP_RST_TIMER_OVR    32'h80000000
`define STP_RST_FWD_MODE     32'h00000002

`define STP_WMASK_TIMER_OVR  32'h7FFF1FFF
`define STP_WMASK_FWD_MODE   32'h00000007
`define STP_LMASK_ROLE_CTRL  32'h00006000
`define STP_LMASK_TIMER_OVR  32'hFFFF7FFF

`define STP_BIT_ROLE_UNLOCK  1
`define STP_BIT_HOTRST_DIS   2
`define STP_BIT_ROLE_DN      3
`define STP_REPLAY_MSB       11
`define STP_BIT_REPLAY_EN    12
`define STP_BIT_PM_CAP_DIS   13
`define STP_BIT_MSI_CAP_DIS  14
`define STP_ACK_LSB          16
`define STP_ACK_MSB          29
`define STP_BIT_ACK_EN       30
`define STP_BIT_VGA_EN       31
`define STP_BIT_STORE_FWD    0
`define STP_THRESH_LSB       1
`define STP_THRESH_MSB       2

`endif

// >>> include/stp_pkg.sv
// Types shared by the port tuning register bank
package stp_pkg;
    typedef logic [31:0] stp_word_t;
    typedef logic [11:0] stp_replay_t;
    typedef logic [13:0] stp_ack_t;
    typedef logic [11:0] stp_len_t;
    typedef enum logic [1:0]
    {
        STP_TH_MID   = 2'b00,
        STP_TH_MID_1 = 2'b01,
        STP_TH_MID_2 = 2'b10,
        STP_TH_MID_3 = 2'b11
    } stp_thresh_t;
endpackage

// >>> verilog/stp_cut_thresh.sv
// Forwarding start point from forwarding mode and cut-through threshold
`timescale 1ns/1ps
module stp_cut_thresh
    import stp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        store_fwd,
    input  wire stp_thresh_t thresh,
    input  wire logic        low_to_high,
    input  wire stp_len_t    pkt_len,
    output stp_len_t         fwd_start
);
    stp_len_t mid;
    stp_len_t next_start;

    assign mid = {1'b0, pkt_len[11:1]};

    always_comb
    begin
        next_start = '0;
        if (store_fwd)
        begin
            // Whole packet must be in before it leaves
            next_start = pkt_len;
        end
        else if (low_to_high)
        begin
            // Slow ingress: start near the middle so egress never starves
            if (mid > stp_len_t'(thresh))
            begin
                next_start = mid - stp_len_t'(thresh);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd_start <= '0;
        end
        else
        begin
            fwd_start <= next_start;
        end
    end
endmodule

// >>> verilog/stp_tuning_regs.sv
// Vendor tuning register bank of a switch port, with its control outputs
//
// Summary of operation
// - LTSSM role changes only while unlock bit set
// - Upstream link loss hot-resets downstream unless disabled or role bit set
// - Role bit: one downstream, zero upstream
// - Of the loaders, only EEPROM replaces role-control bits 14:13
// - 12-bit user replay value, resets zero
// - Replay enable selects user replay value
// - 14-bit user ACK latency, resets zero
// - ACK enable selects user ACK latency
// - Read-only VGA decode enable, default one
// - Store-forward bit selects forwarding, resets zero
// - Threshold applies low-speed to high-speed forwarding
// - Threshold: midpoint, or 1..3 cycles earlier
// - Default loads overwrite timer and mode fields
`timescale 1ns/1ps
`include "stp_cfg.svh"
module stp_tuning_regs
    import stp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Configuration space access
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire stp_word_t   cfg_wdata,
    output stp_word_t        cfg_rdata,
    output logic             cfg_rd_ack,
    // Default loader (SMBus, I2C or EEPROM)
    input  wire logic        ld_valid,
    input  wire logic        ld_eeprom,
    input  wire logic [7:0]  ld_addr,
    input  wire stp_word_t   ld_data,
    // Link and forwarding side
    input  wire logic        uplink_down,
    input  wire stp_replay_t int_replay_limit,
    input  wire stp_ack_t    int_ack_limit,
    input  wire logic        low_to_high,
    input  wire stp_len_t    pkt_len,
    output logic             downstream_role_select,
    output logic             hot_reset_dn,
    output stp_replay_t      replay_limit,
    output stp_ack_t         ack_limit,
    output logic             pm_cap_disable,
    output logic             msi_cap_disable,
    output logic             vga_decode_en,
    output logic             store_fwd,
    output stp_len_t         fwd_start
);
    stp_word_t link_role_test_control;
    stp_word_t link_test_control_aux;
    stp_word_t timer_ovr;
    stp_word_t fwd_mode_control;
    stp_word_t next_role;
    stp_word_t next_rdata;

    function automatic stp_word_t merge(input stp_word_t old_v,
                                        input stp_word_t new_v,
                                        input logic [3:0] be,
                                        input stp_word_t wmask);
        stp_word_t m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    always_comb
    begin
        next_role = merge(link_role_test_control, cfg_wdata, cfg_be,
                          32'hFFFFFFFF);
        if (!link_role_test_control[`STP_BIT_ROLE_UNLOCK])
        begin
            next_role[`STP_BIT_ROLE_DN] =
                link_role_test_control[`STP_BIT_ROLE_DN];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_role_test_control <= `STP_RST_ROLE_CTRL;
        end
        else if (ld_valid && ld_eeprom && hit(ld_addr, `STP_OFF_ROLE_CTRL))
        begin
            link_role_test_control <=
                merge(link_role_test_control, ld_data, 4'hF,
                      `STP_LMASK_ROLE_CTRL);
        end
        else if (cfg_wr && hit(cfg_addr, `STP_OFF_ROLE_CTRL))
        begin
            link_role_test_control <= next_role;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_test_control_aux <= `STP_RST_TEST_AUX;
        end
        else if (cfg_wr && hit(cfg_addr, `STP_OFF_TEST_AUX))
        begin
            link_test_control_aux <= merge(link_test_control_aux, cfg_wdata,
                                           cfg_be, 32'hFFFFFFFF);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_ovr <= `STP_RST_TIMER_OVR;
        end
        else if (ld_valid && hit(ld_addr, `STP_OFF_TIMER_OVR))
        begin
            timer_ovr <= merge(timer_ovr, ld_data, 4'hF,
                               `STP_LMASK_TIMER_OVR);
        end
        else if (cfg_wr && hit(cfg_addr, `STP_OFF_TIMER_OVR))
        begin
            timer_ovr <= merge(timer_ovr, cfg_wdata, cfg_be,
                               `STP_WMASK_TIMER_OVR);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd_mode_control <= `STP_RST_FWD_MODE;
        end
        else if (ld_valid && hit(ld_addr, `STP_OFF_FWD_MODE))
        begin
            fwd_mode_control <= merge(fwd_mode_control, ld_data, 4'hF,
                                      `STP_WMASK_FWD_MODE);
        end
        else if (cfg_wr && hit(cfg_addr, `STP_OFF_FWD_MODE))
        begin
            fwd_mode_control <= merge(fwd_mode_control, cfg_wdata, cfg_be,
                                      `STP_WMASK_FWD_MODE);
        end
    end

    always_comb
    begin
        next_rdata = '0;
        if (hit(cfg_addr, `STP_OFF_ROLE_CTRL))
        begin
            next_rdata = link_role_test_control;
        end
        else if (hit(cfg_addr, `STP_OFF_TEST_AUX))
        begin
            next_rdata = link_test_control_aux;
        end
        else if (hit(cfg_addr, `STP_OFF_TIMER_OVR))
        begin
            next_rdata = timer_ovr;
        end
        else if (hit(cfg_addr, `STP_OFF_FWD_MODE))
        begin
            next_rdata = fwd_mode_control;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata  <= '0;
            cfg_rd_ack <= 1'b0;
        end
        else
        begin
            cfg_rd_ack <= cfg_rd;
            if (cfg_rd)
            begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            downstream_role_select <= 1'b0;
            hot_reset_dn           <= 1'b0;
        end
        else
        begin
            downstream_role_select <= link_role_test_control[`STP_BIT_ROLE_DN];
            // hot reset on upstream link loss
            hot_reset_dn <= uplink_down
                & ~link_role_test_control[`STP_BIT_HOTRST_DIS]
                & ~link_role_test_control[`STP_BIT_ROLE_DN];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            replay_limit <= '0;
            ack_limit    <= '0;
        end
        else
        begin
            replay_limit <= timer_ovr[`STP_BIT_REPLAY_EN]
                ? timer_ovr[`STP_REPLAY_MSB:0] : int_replay_limit;
            ack_limit <= timer_ovr[`STP_BIT_ACK_EN]
                ? timer_ovr[`STP_ACK_MSB:`STP_ACK_LSB] : int_ack_limit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pm_cap_disable  <= 1'b0;
            msi_cap_disable <= 1'b0;
            vga_decode_en   <= 1'b1;
            store_fwd       <= 1'b0;
        end
        else
        begin
            pm_cap_disable  <= timer_ovr[`STP_BIT_PM_CAP_DIS];
            msi_cap_disable <= timer_ovr[`STP_BIT_MSI_CAP_DIS];
            vga_decode_en   <= timer_ovr[`STP_BIT_VGA_EN];
            store_fwd       <= fwd_mode_control[`STP_BIT_STORE_FWD];
        end
    end

    stp_cut_thresh stp_cut_thresh_inst
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .store_fwd   (fwd_mode_control[`STP_BIT_STORE_FWD]),
        .thresh      (stp_thresh_t'(
                      fwd_mode_control[`STP_THRESH_MSB:`STP_THRESH_LSB])),
        .low_to_high (low_to_high),
        .pkt_len     (pkt_len),
        .fwd_start   (fwd_start)
    );

    sequence s_locked_role_write;
        cfg_wr && hit(cfg_addr, `STP_OFF_ROLE_CTRL)
            && !link_role_test_control[`STP_BIT_ROLE_UNLOCK];
    endsequence

    sequence s_unlocked_role_write;
        cfg_wr && hit(cfg_addr, `STP_OFF_ROLE_CTRL) && cfg_be[0]
            && !ld_valid && link_role_test_control[`STP_BIT_ROLE_UNLOCK];
    endsequence

    a_role_locked: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_locked_role_write |=> ##1
            downstream_role_select == $past(link_role_test_control[3], 2))
        else $error("role changed while locked");

    a_role_unlocked: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_unlocked_role_write |=> ##1
            downstream_role_select == $past(cfg_wdata[3], 2))
        else $error("role not taken while unlocked");

    a_hot_reset: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (uplink_down && !link_role_test_control[2]
            && !link_role_test_control[3]) |=> hot_reset_dn)
        else $error("hot reset not issued on link loss");

    a_eeprom_only: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (ld_valid && !ld_eeprom && !cfg_wr) |=>
            $stable(link_role_test_control))
        else $error("role control loaded from non-EEPROM source");

    a_replay_sel: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer_ovr[12] |=> replay_limit == $past(timer_ovr[11:0]))
        else $error("user replay value not used");

    a_ack_sel: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timer_ovr[30] |=> ack_limit == $past(timer_ovr[29:16]))
        else $error("user ack latency not used");

    a_builtin_timer: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!timer_ovr[12] && !timer_ovr[30]) |=>
            (replay_limit == $past(int_replay_limit)
             && ack_limit == $past(int_ack_limit)))
        else $error("built-in timer not used");

    a_vga_ro: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_wr && !ld_valid) |=> ##1 $stable(vga_decode_en))
        else $error("vga decode changed by software write");

    a_fwd_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_wr && hit(cfg_addr, `STP_OFF_FWD_MODE) && cfg_be[0]
            && !ld_valid) |=> ##1 store_fwd == $past(cfg_wdata[0], 2))
        else $error("forwarding mode not written");

    a_thresh_start: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!fwd_mode_control[0] && low_to_high && pkt_len[11:1] > 11'h003)
            |=> fwd_start == $past({1'b0, pkt_len[11:1]}
                - stp_len_t'(fwd_mode_control[2:1])))
        else $error("cut-through start point wrong");

    a_read_ack: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_rd && hit(cfg_addr, `STP_OFF_TIMER_OVR)) |=>
            (cfg_rd_ack && cfg_rdata[15] == 1'b0
             && cfg_rdata == $past(timer_ovr)))
        else $error("timer register read wrong");
endmodule

// >>> tb/stp_tuning_regs_tb.sv
// Self-checking testbench of the switch port tuning register bank
`timescale 1ns/1ps
`include "stp_cfg.svh"
module stp_tuning_regs_tb
    import stp_pkg::*;
;
    logic        clk_sys;
    logic        rst_n;
    logic        cfg_wr;
    logic        cfg_rd;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    stp_word_t   cfg_wdata;
    stp_word_t   cfg_rdata;
    logic        cfg_rd_ack;
    logic        ld_valid;
    logic        ld_eeprom;
    logic [7:0]  ld_addr;
    stp_word_t   ld_data;
    logic        uplink_down;
    stp_replay_t int_replay_limit;
    stp_ack_t    int_ack_limit;
    logic        low_to_high;
    stp_len_t    pkt_len;
    logic        downstream_role_select;
    logic        hot_reset_dn;
    stp_replay_t replay_limit;
    stp_ack_t    ack_limit;
    logic        pm_cap_disable;
    logic        msi_cap_disable;
    logic        vga_decode_en;
    logic        store_fwd;
    stp_len_t    fwd_start;
    int          n_fail;
    int          comparisons;

    stp_tuning_regs stp_tuning_regs_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack),
        .ld_valid(ld_valid), .ld_eeprom(ld_eeprom), .ld_addr(ld_addr),
        .ld_data(ld_data), .uplink_down(uplink_down),
        .int_replay_limit(int_replay_limit), .int_ack_limit(int_ack_limit),
        .low_to_high(low_to_high), .pkt_len(pkt_len),
        .downstream_role_select(downstream_role_select),
        .hot_reset_dn(hot_reset_dn), .replay_limit(replay_limit),
        .ack_limit(ack_limit), .pm_cap_disable(pm_cap_disable),
        .msi_cap_disable(msi_cap_disable), .vga_decode_en(vga_decode_en),
        .store_fwd(store_fwd), .fwd_start(fwd_start)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input stp_word_t got, input stp_word_t exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [3:0] be, input stp_word_t d);
        @(posedge clk_sys);
        #1;
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk_sys);
        #1;
        cfg_wr = 1'b0;
    endtask

    task ld(input logic [7:0] a, input logic ee, input stp_word_t d);
        @(posedge clk_sys);
        #1;
        ld_valid = 1'b1;
        ld_eeprom = ee;
        ld_addr = a;
        ld_data = d;
        @(posedge clk_sys);
        #1;
        ld_valid = 1'b0;
    endtask

    // Waits a bounded number of cycles for the acknowledge pulse
    task rd(input logic [7:0] a, input stp_word_t exp);
        int i;
        @(posedge clk_sys);
        #1;
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge clk_sys);
        #1;
        cfg_rd = 1'b0;
        i = 0;
        while (cfg_rd_ack !== 1'b1 && i < 4)
        begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        chk({31'h0, cfg_rd_ack}, 32'h00000001);
        chk(cfg_rdata, exp);
    endtask

    // Derived outputs follow the register one edge after it updates
    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    initial
    begin
        #75000;
        n_fail++;
        $display("MISMATCH t=%0t watchdog %h %h", $time, 1'b1, 1'b0);
        stop_test();
    end

    initial
    begin
        n_fail = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {cfg_wr, cfg_rd, ld_valid, ld_eeprom, uplink_down} = 5'h00;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
        ld_addr = 8'h00;
        ld_data = 32'h00000000;
        int_replay_limit = 12'hABC;
        int_ack_limit = 14'h1234;
        low_to_high = 1'b0;
        pkt_len = 12'h064;
        repeat (5) @(posedge clk_sys);
        #1;
        chk({31'h0, vga_decode_en}, 32'h00000001);
        rst_n = 1'b1;
        settle();
        rd(`STP_OFF_ROLE_CTRL, `STP_RST_ROLE_CTRL);
        rd(`STP_OFF_TEST_AUX, `STP_RST_TEST_AUX);
        rd(`STP_OFF_TIMER_OVR, `STP_RST_TIMER_OVR);
        rd(`STP_OFF_FWD_MODE, `STP_RST_FWD_MODE);
        rd(8'h78, 32'h00000000);
        wr(8'h78, 4'hF, 32'hFFFFFFFF);
        rd(8'h78, 32'h00000000);
        wr(`STP_OFF_TEST_AUX, 4'hF, 32'h12345678);
        rd(`STP_OFF_TEST_AUX, 32'h12345678);
        chk({20'h0, replay_limit}, 32'h00000ABC);
        chk({18'h0, ack_limit}, 32'h00001234);
        chk({31'h0, store_fwd}, 32'h00000000);
        $display("test reset_values done");

        uplink_down = 1'b1;
        settle();
        chk({31'h0, hot_reset_dn}, 32'h00000001);
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h04001064);
        settle();
        chk({31'h0, hot_reset_dn}, 32'h00000000);
        uplink_down = 1'b0;
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h04001068);
        settle();
        rd(`STP_OFF_ROLE_CTRL, 32'h04001060);
        chk({31'h0, downstream_role_select}, 32'h00000000);
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h04001062);
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h0400106A);
        settle();
        rd(`STP_OFF_ROLE_CTRL, 32'h0400106A);
        chk({31'h0, downstream_role_select}, 32'h00000001);
        uplink_down = 1'b1;
        settle();
        chk({31'h0, hot_reset_dn}, 32'h00000000);
        uplink_down = 1'b0;
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h04001060);
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h0400106A);
        settle();
        rd(`STP_OFF_ROLE_CTRL, 32'h04001062);
        chk({31'h0, downstream_role_select}, 32'h00000000);
        wr(`STP_OFF_ROLE_CTRL, 4'hF, 32'h0400106A);
        $display("test role_control done");

        wr(`STP_OFF_TIMER_OVR, 4'hF, 32'hFFFFFFFF);
        settle();
        rd(`STP_OFF_TIMER_OVR, 32'hFFFF1FFF);
        chk({20'h0, replay_limit}, 32'h00000FFF);
        chk({18'h0, ack_limit}, 32'h00003FFF);
        chk({31'h0, vga_decode_en}, 32'h00000001);
        wr(`STP_OFF_TIMER_OVR, 4'hF, 32'h3FFF0FFF);
        wr(`STP_OFF_TIMER_OVR, 4'h1, 32'hAAAAAA55);
        settle();
        rd(`STP_OFF_TIMER_OVR, 32'hBFFF0F55);
        chk({20'h0, replay_limit}, 32'h00000ABC);
        chk({18'h0, ack_limit}, 32'h00001234);
        wr(`STP_OFF_TIMER_OVR, 4'hF, 32'h55551123);
        settle();
        chk({20'h0, replay_limit}, 32'h00000123);
        chk({18'h0, ack_limit}, 32'h00001555);
        $display("test timer_override done");

        ld(`STP_OFF_TIMER_OVR, 1'b0, 32'h00006000);
        settle();
        rd(`STP_OFF_TIMER_OVR, 32'h00006000);
        chk({29'h0, vga_decode_en, pm_cap_disable, msi_cap_disable},
            32'h00000003);
        ld(`STP_OFF_ROLE_CTRL, 1'b0, 32'hFFFFFFFF);
        rd(`STP_OFF_ROLE_CTRL, 32'h0400106A);
        ld(`STP_OFF_ROLE_CTRL, 1'b1, 32'hFFFFFFFF);
        rd(`STP_OFF_ROLE_CTRL, 32'h0400706A);
        ld(`STP_OFF_FWD_MODE, 1'b0, 32'hFFFFFFFF);
        settle();
        rd(`STP_OFF_FWD_MODE, 32'h00000007);
        chk({31'h0, store_fwd}, 32'h00000001);
        chk({20'h0, fwd_start}, 32'h00000064);
        $display("test default_load done");

        low_to_high = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            wr(`STP_OFF_FWD_MODE, 4'hF, 32'hFFFFFFF8 | (t << 1));
            settle();
            rd(`STP_OFF_FWD_MODE, t << 1);
            chk({20'h0, fwd_start}, 32'h00000032 - t);
        end
        pkt_len = 12'h004;
        settle();
        chk({20'h0, fwd_start}, 32'h00000000);
        low_to_high = 1'b0;
        pkt_len = 12'h064;
        settle();
        chk({20'h0, fwd_start}, 32'h00000000);
        chk({31'h0, store_fwd}, 32'h00000000);
        $display("test cut_through done");
        stop_test();
    end
endmodule
